// ---- pat_arb_table.sv ----
// Our own choice: the APB register port.
`timescale 1ns/10ps
// Overview of operation
// - Word 0 holds slots 0..7, slot n in bits 4n+3:4n, naming owning port.
// - Words 1 and 2 hold slots 8..15 and 16..23, ascending from bit 0.
// - Code 0 upstream, code 2 second downstream, code 4 third; rest reserved.
// - A slot with an invalid port is skipped with no idle period.
// - Reset: slots 0..6 hold 1..7, slot 7 holds 1.
// - Reset: slots 8..13 hold 2..7, slot 14 holds 1, slot 15 holds 2.
// - Reset: slots 16..20 hold 3..7, slots 21..23 hold 1,2,3.
// - Writing one to load bit copies table to arbiter; writing zero does nothing.
// - Pending bit sets on any table write, stays until load completes.
// - Load and pending act only in upstream port; downstream pending reads zero.
// - Table is used only when selected scheme relies on the phase table.
module pat_arb_table (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	input  wire logic        is_upstream,
	input  wire logic        period_done,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [2:0]  grant_onehot,
	output logic             grant_valid,
	output logic      [4:0]  grant_phase
);
	typedef struct packed {
		logic [2:0][31:0] table_w;
		logic [2:0][31:0] active_w;
		logic [2:0]       scheme;
		logic             pending;
		pat_pkg::pat_load_e load_st;
		logic [1:0]       load_cnt;
		logic [31:0]      rdata;
		logic             slverr;
		logic             resp;
	} pat_top_s;

	pat_top_s st_reg;
	pat_top_s st_next;

	pat_grant_if gif ();

	function automatic logic [2:0] pat_word_sel(input logic [11:0] a);
		case (a)
			pat_pkg::OFF_TABLE_WORD0: pat_word_sel = 3'h1;
			pat_pkg::OFF_TABLE_WORD1: pat_word_sel = 3'h2;
			pat_pkg::OFF_TABLE_WORD2: pat_word_sel = 3'h4;
			default:                  pat_word_sel = 3'h0;
		endcase
	endfunction

	function automatic logic [31:0] pat_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			pat_merge[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
	endfunction

	logic        access;
	logic        wr_take;
	logic        rd_take;
	logic        sel_ctrl;
	logic        sel_status;
	logic        sel_none;
	logic        ctrl_byte2;
	logic [2:0]  wsel;
	logic [2:0]  word_wr;
	logic [31:0] word_new [3];

	assign access     = psel && penable;
	// Writes land only at the edge that completes the transfer
	assign wr_take    = access && pwrite && st_reg.resp;
	// Read data and error are captured in the first access cycle
	assign rd_take    = access && !st_reg.resp;
	assign wsel       = pat_word_sel(paddr);
	assign sel_ctrl   = paddr == pat_pkg::OFF_CTRL;
	assign sel_status = paddr == pat_pkg::OFF_STATUS;
	assign sel_none   = wsel == 3'h0 && !sel_ctrl && !sel_status;
	assign ctrl_byte2 = wr_take && sel_ctrl && pstrb[2];

	// Write strobe and byte-merged value for each table word
	genvar gw;
	generate
		for (gw = 0; gw < pat_pkg::NUM_WORDS; gw++) begin : g_word
			assign word_wr[gw]  = wr_take && wsel[gw];
			assign word_new[gw] = pat_merge(st_reg.table_w[gw], pwdata, pstrb);
		end
	endgenerate

	always_comb begin
		logic load_req;
		load_req = ctrl_byte2 && pwdata[pat_pkg::CTRL_LOAD_BIT] && is_upstream;
		st_next = st_reg;
		// Exactly one wait state before every response
		st_next.resp = access && !st_reg.resp;
		for (int w = 0; w < pat_pkg::NUM_WORDS; w++) begin
			if (word_wr[w]) begin
				st_next.table_w[w] = word_new[w];
			end
		end
		if (ctrl_byte2) begin
			st_next.scheme = pwdata[pat_pkg::CTRL_SCHEME_LSB +: 3];
		end
		case (st_reg.load_st)
			pat_pkg::PAT_IDLE: begin
				if (load_req) begin
					st_next.load_st  = pat_pkg::PAT_COPY;
					st_next.load_cnt = pat_pkg::LOAD_CYCLES;
				end
			end
			pat_pkg::PAT_COPY: begin
				st_next.active_w = st_reg.table_w;
				st_next.load_cnt = st_reg.load_cnt - 2'h1;
				if (st_reg.load_cnt == 2'h1) begin
					st_next.load_st = pat_pkg::PAT_DONE;
				end
			end
			pat_pkg::PAT_DONE: begin
				st_next.pending  = 1'b0;
				st_next.load_st  = load_req ? pat_pkg::PAT_COPY : pat_pkg::PAT_IDLE;
				st_next.load_cnt = pat_pkg::LOAD_CYCLES;
			end
			default: begin
				st_next.load_st = pat_pkg::PAT_IDLE;
			end
		endcase
		// A table write in the cycle the load finishes keeps pending set
		if (word_wr != 3'h0 && is_upstream) begin
			st_next.pending = 1'b1;
		end
		if (!is_upstream) begin
			st_next.pending = 1'b0;
		end
		st_next.rdata  = 32'h0000_0000;
		st_next.slverr = 1'b0;
		if (rd_take && !pwrite) begin
			for (int w = 0; w < pat_pkg::NUM_WORDS; w++) begin
				if (wsel[w]) begin
					st_next.rdata = st_reg.table_w[w];
				end
			end
			if (sel_ctrl) begin
				st_next.rdata[pat_pkg::CTRL_SCHEME_LSB +: 3] = st_reg.scheme;
			end
			if (sel_status) begin
				st_next.rdata[pat_pkg::STAT_PEND_BIT] = st_reg.pending && is_upstream;
			end
		end
		if (rd_take && sel_none) begin
			st_next.slverr = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.table_w[0] <= pat_pkg::RST_TABLE_WORD0;
			st_reg.table_w[1] <= pat_pkg::RST_TABLE_WORD1;
			st_reg.table_w[2] <= pat_pkg::RST_TABLE_WORD2;
			st_reg.active_w[0] <= pat_pkg::RST_TABLE_WORD0;
			st_reg.active_w[1] <= pat_pkg::RST_TABLE_WORD1;
			st_reg.active_w[2] <= pat_pkg::RST_TABLE_WORD2;
			st_reg.load_st <= pat_pkg::PAT_IDLE;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign pready  = st_reg.resp;
	assign prdata  = st_reg.rdata;
	assign pslverr = st_reg.resp && st_reg.slverr;

	assign gif.active_table = st_reg.active_w;
	assign gif.table_used   = pat_pkg::TABLE_SCHEMES[st_reg.scheme];
	assign gif.period_done  = period_done;

	pat_phase_seq u_seq (
		.core_clk (core_clk),
		.srst     (srst),
		.clk_en   (clk_en),
		.gif      (gif)
	);

	assign grant_onehot = gif.grant_onehot;
	assign grant_valid  = gif.grant_valid;
	assign grant_phase  = gif.phase;
endmodule

// ---- pat_pkg.sv ----
package pat_pkg;
	localparam int         NUM_WORDS        = 3;
	localparam int         SLOTS_PER_WORD   = 8;
	localparam int         NUM_SLOTS        = 24;
	localparam int         SLOT_W           = 4;
	localparam logic [4:0] LAST_SLOT        = 5'h17;
	localparam logic [11:0] OFF_TABLE_WORD0 = 12'h220;
	localparam logic [11:0] OFF_TABLE_WORD1 = 12'h224;
	localparam logic [11:0] OFF_TABLE_WORD2 = 12'h228;
	localparam logic [11:0] OFF_CTRL        = 12'h214;
	localparam logic [11:0] OFF_STATUS      = 12'h218;
	localparam int         CTRL_LOAD_BIT    = 16;
	localparam int         CTRL_SCHEME_LSB  = 17;
	localparam int         STAT_PEND_BIT    = 16;
	localparam logic [31:0] RST_TABLE_WORD0 = 32'h1765_4321;
	localparam logic [31:0] RST_TABLE_WORD1 = 32'h2176_5432;
	localparam logic [31:0] RST_TABLE_WORD2 = 32'h3217_6543;
	localparam logic [3:0] PORT_UP          = 4'h0;
	localparam logic [3:0] PORT_DN2         = 4'h2;
	localparam logic [3:0] PORT_DN4         = 4'h4;
	localparam logic [7:0] TABLE_SCHEMES    = 8'hfe;
	localparam logic [1:0] LOAD_CYCLES      = 2'h2;
	typedef enum logic [2:0] {
		PAT_IDLE = 3'h1,
		PAT_COPY = 3'h2,
		PAT_DONE = 3'h4
	} pat_load_e;
endpackage

// ---- pat_grant_if.sv ----
`timescale 1ns/10ps
interface pat_grant_if;
	logic [95:0] active_table;
	logic        table_used;
	logic        period_done;
	logic [2:0]  grant_onehot;
	logic        grant_valid;
	logic [4:0]  phase;
	modport ctrl (output active_table, output table_used, output period_done,
		input grant_onehot, input grant_valid, input phase);
	modport seq (input active_table, input table_used, input period_done,
		output grant_onehot, output grant_valid, output phase);
endinterface

// ---- pat_phase_seq.sv ----
`timescale 1ns/10ps
module pat_phase_seq (
	input  wire logic   core_clk,
	input  wire logic   srst,
	input  wire logic   clk_en,
	pat_grant_if.seq    gif
);
	typedef struct packed {
		logic [4:0] phase;
		logic [2:0] grant;
		logic       valid;
	} pat_seq_s;

	pat_seq_s st_reg;
	pat_seq_s st_next;

	function automatic logic [2:0] pat_decode(input logic [3:0] code);
		case (code)
			pat_pkg::PORT_UP:  pat_decode = 3'h1;
			pat_pkg::PORT_DN2: pat_decode = 3'h2;
			pat_pkg::PORT_DN4: pat_decode = 3'h4;
			default:           pat_decode = 3'h0;
		endcase
	endfunction

	function automatic logic [4:0] pat_incr(input logic [4:0] p);
		pat_incr = (p == pat_pkg::LAST_SLOT) ? 5'h00 : p + 5'h01;
	endfunction

	always_comb begin
		logic [4:0] p;
		logic       found;
		p = st_reg.phase;
		found = 1'b0;
		st_next = st_reg;
		if (!gif.table_used) begin
			st_next.valid = 1'b0;
			st_next.grant = 3'h0;
		end else if (gif.period_done || !st_reg.valid) begin
			if (st_reg.valid)
				p = pat_incr(p);
			// Invalid slots are passed over in the same cycle
			for (int i = 0; i < pat_pkg::NUM_SLOTS; i++) begin
				if (!found && pat_decode(gif.active_table[p*pat_pkg::SLOT_W +: 4]) != 3'h0)
					found = 1'b1;
				else if (!found)
					p = pat_incr(p);
			end
			st_next.phase = p;
			st_next.valid = found;
			st_next.grant = found ? pat_decode(gif.active_table[p*pat_pkg::SLOT_W +: 4])
				: 3'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end

	assign gif.grant_onehot = st_reg.grant;
	assign gif.grant_valid  = st_reg.valid;
	assign gif.phase        = st_reg.phase;
endmodule

// ---- pat_arb_table_properties.sv ----
`timescale 1ns/10ps
module pat_arb_table_properties (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        clk_en,
	input wire logic        is_upstream,
	input wire logic        period_done,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  grant_onehot,
	input wire logic        grant_valid,
	input wire logic [4:0]  grant_phase
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_ready_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	chk_ready_single: assert property (pready |=> !pready) else $error("pready held too long");
	chk_err_unmapped: assert property (pready |-> pslverr ==
		!(paddr inside {12'h214, 12'h218, 12'h220, 12'h224, 12'h228})) else $error("bad pslverr");
	chk_grant_onehot: assert property (grant_valid |-> $onehot(grant_onehot))
		else $error("grant not one port");
	// Cycles next to a completing write are left out: a scheme write may stop the table
	chk_no_idle: assert property (grant_valid && period_done && !pready && !$past(pready)
		|=> grant_valid) else $error("idle period after grant");
	chk_phase_step: assert property (grant_valid && period_done && !pready && !$past(pready)
		|=> grant_phase != $past(grant_phase)) else $error("phase did not advance");
	chk_phase_range: assert property (grant_phase <= 5'h17) else $error("phase out of range");
	chk_pend_down: assert property (pready && !pwrite && !is_upstream && paddr == 12'h218
		|-> !prdata[16]) else $error("pending set in downstream port");
	chk_reset_idle: assert property (disable iff (1'b0) srst |=> !grant_valid && !pready)
		else $error("activity after reset");
	cover property (pready && pwrite);
	cover property (pready && pslverr);
	cover property (grant_valid && period_done);
endmodule

bind pat_arb_table pat_arb_table_properties u_pat_arb_table_properties (.core_clk, .srst,
	.clk_en, .is_upstream, .period_done, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .grant_onehot, .grant_valid, .grant_phase);

// ---- pat_port_model.sv ----
`timescale 1ns/10ps
module pat_port_model (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic grant_valid,
	input  wire logic slow,
	output logic      period_done
);
	logic [1:0] cnt_reg;
	// Ends each granted period at once, or after two extra cycles when slow
	assign period_done = grant_valid && (cnt_reg == (slow ? 2'h2 : 2'h0));
	always_ff @(posedge core_clk) begin
		if (srst || period_done || !grant_valid)
			cnt_reg <= 2'h0;
		else
			cnt_reg <= cnt_reg + 2'h1;
	end
endmodule

// ---- pat_arb_table_bench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module pat_arb_table_bench;
	logic        core_clk = 1'h0, srst = 1'h1, clk_en = 1'h1, is_upstream = 1'h1, slow = 1'h0;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
	logic        period_done, pready, pslverr, grant_valid;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic [2:0]  grant_onehot;
	logic [4:0]  grant_phase;
	int          fail_count = 0, checked = 0, cyc = 0;
	always #5 core_clk = ~core_clk;
	pat_arb_table u_pat_arb_table (.core_clk, .srst, .clk_en, .is_upstream, .period_done, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .grant_onehot,
		.grant_valid, .grant_phase);
	pat_port_model u_pat_port_model (.core_clk, .srst, .grant_valid, .slow, .period_done);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic t_reset;
		apb(1'h0, 12'h220, 32'h0);
		`CHK("word0", 32'h1765_4321, rd)
		apb(1'h0, 12'h224, 32'h0);
		`CHK("word1", 32'h2176_5432, rd)
		apb(1'h0, 12'h228, 32'h0);
		`CHK("word2", 32'h3217_6543, rd)
		`CHK("idle grant", 1'h0, grant_valid)
		$display("test reset done");
	endtask
	task automatic t_seq(input logic s);
		logic [4:0] ph [7] = '{5'h01, 5'h03, 5'h08, 5'h0a, 5'h0f, 5'h11, 5'h16};
		slow <= s;
		apb(1'h1, 12'h214, 32'h0003_0000);
		do @(negedge core_clk); while (!(period_done === 1'h1 && grant_phase === 5'h01));
		for (int k = 0; k < 9; k++) begin
			`CHK("phase", ph[k % 7], grant_phase)
			`CHK("port", ((k % 7) % 2 ? 3'h4 : 3'h2), grant_onehot)
			do @(negedge core_clk); while (period_done !== 1'h1);
		end
		$display("test sequence done");
	endtask
	task automatic t_load;
		apb(1'h1, 12'h224, 32'h4444_2222);
		apb(1'h0, 12'h224, 32'h0);
		`CHK("word1", 32'h4444_2222, rd)
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h1, rd[16])
		apb(1'h1, 12'h214, 32'h0002_0000);
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h1, rd[16])
		apb(1'h1, 12'h214, 32'h0003_0000);
		repeat (4) @(posedge core_clk);
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h0, rd[16])
		do @(negedge core_clk); while (!(period_done === 1'h1 && grant_phase === 5'h0c));
		`CHK("new port", 3'h4, grant_onehot)
		$display("test load done");
	endtask
	task automatic t_down;
		apb(1'h1, 12'h228, 32'h2424_2424);
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h1, rd[16])
		is_upstream <= 1'h0;
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h0, rd[16])
		apb(1'h1, 12'h224, 32'h2222_4444);
		apb(1'h0, 12'h218, 32'h0);
		`CHK("pending", 1'h0, rd[16])
		apb(1'h0, 12'h21c, 32'h0);
		`CHK("error", 1'h1, err)
		is_upstream <= 1'h1;
		$display("test downstream done");
	endtask
	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'h0;
		t_reset;
		t_seq(1'h0);
		t_seq(1'h1);
		t_load;
		t_down;
		test_done;
	end
endmodule
